// [core/brs_pkg.sv]
/*
  Constants, state encodings and timing counts for the bridge reset sequencer.
  Assumes a single 200 MHz core clock and that every user of it imports the
  whole package.
*/
// Behaviour
// - Hold power-on reset until supply good.
// - After clock detected, wait 10 us, release.
// - Power-on reset initializes every register class.
// - Secondary bus reset follows every reset source.
// - Fundamental reset clears all non-sticky state.
// - Fundamental reset release latches static inputs.
// - Release starts download when EEPROM present.
// - Link training starts within 80 ms.
// - Hot reset enters data-link-down state.
// - Link-down resets ordinary bits only.
// - Sticky bits cleared by global or power-on.
// - Loadable bits cleared by fundamental, global, power-on.
// - Bridge control bit 6 drives bus reset.
// - Reference select: low 100 MHz, high 125 MHz.
// - No beacon, wake or auxiliary power.
// - Global reset restores all link registers.
package brs_pkg;

  localparam int unsigned CLK_MHZ = 200;

  // Power-on release delay after the reference clock is seen active.
  localparam int unsigned POR_DELAY_US = 10;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam logic [11:0] POR_DELAY_LAST = 12'(POR_DELAY_CYC - 1);

  // Longest time from fundamental reset release to training start.
  localparam int unsigned LINK_TRAIN_MAX_MS = 80;
  localparam int unsigned LINK_TRAIN_MAX_CYC_DEF = LINK_TRAIN_MAX_MS * CLK_MHZ * 1000;

  // Bridge control register and its secondary bus reset field.
  localparam logic [7:0] BRIDGE_CTRL_OFS = 8'h3e;
  localparam int unsigned SBR_BIT = 6;

  localparam int unsigned STATIC_W = 8;

  // Level that a reset flop takes while its reset is in effect.
  localparam logic RST_ASSERTED = 1'b1;

  typedef enum logic [1:0] {
    POR_PWR = 2'b00,
    POR_CLK = 2'b01,
    POR_DLY = 2'b10,
    POR_RUN = 2'b11
  } brs_por_e;

endpackage

// [core/brs_rst_sync.sv]
/*
  Reset synchronizer: asserts at once on its asynchronous input, releases two
  clock edges after that input falls. Assumes clk_i runs while reset releases.
*/
`timescale 1ns/1ps
module brs_rst_sync
  import brs_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_i,
  output logic rst_o
);

  typedef struct packed {
    logic s1;
    logic s2;
  } brs_sync_s;

  brs_sync_s sync_ff;
  brs_sync_s nxt_sync;

  always_comb
  begin
    nxt_sync.s1 = ~RST_ASSERTED;
    nxt_sync.s2 = sync_ff.s1;
  end

  always_ff @(posedge clk_i or posedge arst_i)
  begin
    if (arst_i)
    begin
      sync_ff <= {RST_ASSERTED, RST_ASSERTED};
    end
    else
    begin
      sync_ff <= nxt_sync;
    end
  end

  assign rst_o = sync_ff.s2;

endmodule

// [core/brs_reset_seq.sv]
/*
  Reset sequencer of the bridge: power-on sequencing, fundamental, global and
  hot reset handling, per-class reset outputs, secondary bus reset and
  reference clock type selection. Assumes pins are asynchronous to clk_i and
  that hot_reset_i, link_up_i, phy_ready_i, eeprom_present_i and the
  configuration write port come from logic on clk_i.
*/
`timescale 1ns/1ps
module brs_reset_seq
  import brs_pkg::*;
#(
  parameter int unsigned LINK_TRAIN_MAX_CYC = LINK_TRAIN_MAX_CYC_DEF
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_supply_sense_i,
  input wire logic refclk_active_i,
  input wire logic fund_reset_n_i,
  input wire logic global_reset_in_n_i,
  input wire logic ref_clock_type_select_i,
  input wire logic [STATIC_W-1:0] static_ctrl_i,
  input wire logic eeprom_present_i,
  input wire logic hot_reset_i,
  input wire logic link_up_i,
  input wire logic phy_ready_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic por_o,
  output logic sticky_rst_o,
  output logic eeprom_rst_o,
  output logic ordinary_rst_o,
  output logic sec_bus_rst_o,
  output logic secondary_bus_reset_bit_o,
  output logic dl_down_o,
  output logic [STATIC_W-1:0] static_ctrl_o,
  output logic eeprom_dl_start_o,
  output logic link_cfg_o,
  output logic link_train_start_o,
  output logic ref_diff100_o,
  output logic ref_se125_o,
  output logic beacon_o,
  output logic wake_o,
  output logic aux_power_en_o
);

  localparam logic [23:0] LINK_LAST = 24'(LINK_TRAIN_MAX_CYC - 1);

  typedef struct packed {
    logic supply_s1;
    logic supply_s2;
    logic clk_s1;
    logic clk_s2;
    logic rsel_s1;
    logic rsel_s2;
    logic [STATIC_W-1:0] stat_s1;
    logic [STATIC_W-1:0] stat_s2;
    brs_por_e st;
    logic [11:0] cnt;
    logic perst_q;
    logic [23:0] link_cnt;
    logic trained;
    logic por;
    logic sticky;
    logic eeprom;
    logic ordinary;
    logic sec_bus;
    logic sbr;
    logic dl_down;
    logic [STATIC_W-1:0] static_q;
    logic dl_start;
    logic link_cfg;
    logic train_start;
    logic ref_diff100;
    logic ref_se125;
    logic beacon;
    logic wake;
    logic aux;
  } brs_state_s;

  brs_state_s state_ff;
  brs_state_s nxt_state;
  logic global_reset_in_rst;
  logic perst_rst;
  logic perst_any;
  logic perst_rise;

  //////////////////////////////////////////////////////////////////////////////

  brs_rst_sync u_global_reset_in_sync (
    .clk_i (clk_i),
    .arst_i (rst_i | ~global_reset_in_n_i),
    .rst_o (global_reset_in_rst)
  );

  brs_rst_sync u_perst_sync (
    .clk_i (clk_i),
    .arst_i (rst_i | ~fund_reset_n_i),
    .rst_o (perst_rst)
  );

  // The power-on reset counts as a fundamental reset, so a release edge seen
  // while power-on is still active is deferred rather than lost.
  assign perst_any = perst_rst | global_reset_in_rst | state_ff.por;
  assign perst_rise = state_ff.perst_q & ~perst_any;

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.supply_s1 = core_supply_sense_i;
    nxt_state.supply_s2 = state_ff.supply_s1;
    nxt_state.clk_s1 = refclk_active_i;
    nxt_state.clk_s2 = state_ff.clk_s1;
    nxt_state.rsel_s1 = ref_clock_type_select_i;
    nxt_state.rsel_s2 = state_ff.rsel_s1;
    nxt_state.stat_s1 = static_ctrl_i;
    nxt_state.stat_s2 = state_ff.stat_s1;
    nxt_state.perst_q = perst_any;

    unique case (state_ff.st)
      POR_PWR:
      begin
        nxt_state.cnt = '0;
        nxt_state.st = POR_CLK;
      end
      POR_CLK:
      begin
        nxt_state.cnt = '0;
        if (state_ff.clk_s2)
        begin
          nxt_state.st = POR_DLY;
        end
      end
      POR_DLY:
      begin
        if (!state_ff.clk_s2)
        begin
          nxt_state.st = POR_CLK;
        end
        else if (state_ff.cnt == POR_DELAY_LAST)
        begin
          nxt_state.st = POR_RUN;
        end
        else
        begin
          nxt_state.cnt = state_ff.cnt + 12'h001;
        end
      end
      POR_RUN:
      begin
        nxt_state.cnt = '0;
      end
    endcase
    if (!state_ff.supply_s2)
    begin
      nxt_state.st = POR_PWR;
    end
    nxt_state.por = (nxt_state.st != POR_RUN);

    // sticky only by power-on or global
    nxt_state.sticky = nxt_state.por | global_reset_in_rst;
    nxt_state.eeprom = nxt_state.sticky | perst_rst;
    nxt_state.dl_down = hot_reset_i | (state_ff.dl_down & ~link_up_i & ~perst_any);
    nxt_state.ordinary = nxt_state.eeprom | nxt_state.dl_down;

    if (nxt_state.ordinary)
    begin
      nxt_state.sbr = 1'b0;
    end
    else if (cfg_wr_i && cfg_addr_i == BRIDGE_CTRL_OFS)
    begin
      nxt_state.sbr = cfg_wdata_i[SBR_BIT];
    end
    nxt_state.sec_bus = nxt_state.ordinary | nxt_state.sbr;

    if (perst_rise)
    begin
      nxt_state.static_q = state_ff.stat_s2;
    end
    nxt_state.dl_start = perst_rise & eeprom_present_i;

    nxt_state.train_start = 1'b0;
    if (perst_any)
    begin
      nxt_state.link_cfg = 1'b0;
      nxt_state.link_cnt = '0;
      nxt_state.trained = 1'b0;
    end
    else if (perst_rise)
    begin
      nxt_state.link_cfg = 1'b1;
      nxt_state.link_cnt = '0;
    end
    else if (state_ff.link_cfg && !state_ff.trained)
    begin
      if (phy_ready_i || state_ff.link_cnt == LINK_LAST)
      begin
        nxt_state.train_start = 1'b1;
        nxt_state.trained = 1'b1;
      end
      else
      begin
        nxt_state.link_cnt = state_ff.link_cnt + 24'h000001;
      end
    end

    nxt_state.ref_diff100 = ~state_ff.rsel_s2;
    nxt_state.ref_se125 = state_ff.rsel_s2;
    nxt_state.beacon = 1'b0;
    nxt_state.wake = 1'b0;
    nxt_state.aux = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= '0;
      state_ff.st <= POR_PWR;
      state_ff.por <= RST_ASSERTED;
      state_ff.sticky <= RST_ASSERTED;
      state_ff.eeprom <= RST_ASSERTED;
      state_ff.ordinary <= RST_ASSERTED;
      state_ff.sec_bus <= RST_ASSERTED;
      state_ff.perst_q <= RST_ASSERTED;
      state_ff.ref_diff100 <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign por_o = state_ff.por;
  assign sticky_rst_o = state_ff.sticky;
  assign eeprom_rst_o = state_ff.eeprom;
  assign ordinary_rst_o = state_ff.ordinary;
  assign sec_bus_rst_o = state_ff.sec_bus;
  assign secondary_bus_reset_bit_o = state_ff.sbr;
  assign dl_down_o = state_ff.dl_down;
  assign static_ctrl_o = state_ff.static_q;
  assign eeprom_dl_start_o = state_ff.dl_start;
  assign link_cfg_o = state_ff.link_cfg;
  assign link_train_start_o = state_ff.train_start;
  assign ref_diff100_o = state_ff.ref_diff100;
  assign ref_se125_o = state_ff.ref_se125;
  assign beacon_o = state_ff.beacon;
  assign wake_o = state_ff.wake;
  assign aux_power_en_o = state_ff.aux;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_delay_end;
    state_ff.st == POR_DLY && state_ff.cnt == POR_DELAY_LAST && state_ff.clk_s2;
  endsequence

  sequence s_release;
    state_ff.supply_s2 ##0 s_delay_end;
  endsequence

  a_por_supply: assert property (!state_ff.supply_s2 |=> por_o)
    else $error("power-on reset not held with low supply");
  a_por_release: assert property ($fell(por_o) |-> $past(state_ff.st == POR_DLY)
    && $past(state_ff.cnt) == POR_DELAY_LAST)
    else $error("power-on reset released without full delay");
  a_por_timely: assert property (s_release |=> !por_o)
    else $error("power-on reset not released after delay");
  a_por_all: assert property (por_o |-> sticky_rst_o && eeprom_rst_o && ordinary_rst_o)
    else $error("power-on reset misses a register class");
  a_bus_reset: assert property (ordinary_rst_o || secondary_bus_reset_bit_o |-> sec_bus_rst_o)
    else $error("secondary bus reset not asserted");
  a_perst_clear: assert property (perst_rst |=> ordinary_rst_o && eeprom_rst_o)
    else $error("fundamental reset did not clear state");
  a_static_latch: assert property (perst_rise |=> static_ctrl_o == $past(state_ff.stat_s2))
    else $error("static inputs not latched on release");
  a_dl_start: assert property (eeprom_dl_start_o |-> $past(perst_rise && eeprom_present_i))
    else $error("download start without release and EEPROM");
  a_train_bound: assert property (link_cfg_o && !state_ff.trained
    |-> state_ff.link_cnt <= LINK_LAST)
    else $error("link training start overdue");
  a_hot_down: assert property (hot_reset_i |=> dl_down_o && ordinary_rst_o)
    else $error("hot reset did not enter link down");
  a_hot_spare: assert property (dl_down_o && !$past(perst_rst) && !$past(global_reset_in_rst)
    && !por_o |-> !eeprom_rst_o && !sticky_rst_o)
    else $error("link down touched sticky or loadable bits");
  a_sticky_src: assert property (sticky_rst_o |-> por_o || $past(global_reset_in_rst))
    else $error("sticky reset from a wrong source");
  a_eeprom_src: assert property (eeprom_rst_o && !sticky_rst_o |-> $past(perst_rst))
    else $error("loadable reset from a wrong source");
  a_sbr_write: assert property (cfg_wr_i && cfg_addr_i == BRIDGE_CTRL_OFS
    && cfg_wdata_i[SBR_BIT] && !ordinary_rst_o && !perst_any && !hot_reset_i
    && state_ff.supply_s2 && state_ff.st == POR_RUN
    |=> secondary_bus_reset_bit_o && sec_bus_rst_o)
    else $error("bus reset bit write not applied");
  a_ref_sel: assert property (ref_se125_o == $past(state_ff.rsel_s2)
    && ref_diff100_o == !ref_se125_o)
    else $error("reference clock type mismatch");
  a_no_wake: assert property (!beacon_o && !wake_o && !aux_power_en_o)
    else $error("beacon, wake or aux power driven");
  a_global_reset_in_all: assert property (global_reset_in_rst |=> sticky_rst_o && ordinary_rst_o)
    else $error("global reset did not clear link registers");

endmodule

// [dv/brs_upstream.sv]
/*
  Upstream port model: orders supply, reference clock and fundamental reset.
  Assumes requests from the bench change off the rising edge of clk_i.
*/
`timescale 1ns/1ps
module brs_upstream (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwr_req_i,
  input wire logic perst_req_i,
  output logic supply_o,
  output logic refclk_o,
  output logic fund_reset_n_o
);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      supply_o <= 1'b0;
      refclk_o <= 1'b0;
      fund_reset_n_o <= 1'b0;
    end
    else if (!pwr_req_i)
    begin
      fund_reset_n_o <= 1'b0;
      refclk_o <= refclk_o & fund_reset_n_o;
      supply_o <= supply_o & refclk_o;
    end
    else
    begin
      supply_o <= 1'b1;
      refclk_o <= supply_o;
      fund_reset_n_o <= refclk_o & perst_req_i;
    end
  end
endmodule

// [dv/bridge_reset_sequencer_tb.sv]
/*
  Self-checking bench of the reset sequencer with an upstream port model.
  Assumes brs_pkg is compiled first; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module bridge_reset_sequencer_tb;
  import brs_pkg::*;
  localparam int unsigned LTC = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pwr_req = 1'b0, perst_req = 1'b0, gl_n = 1'b1, sel = 1'b0, eep = 1'b0;
  logic hot = 1'b0, lup = 1'b0, phy = 1'b0, wr = 1'b0;
  logic [STATIC_W-1:0] stat = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] lfsr_q = 16'hbe2f;
  logic sup, rck, fund_n;
  logic por, stk, eer, ordr, sbr, sbit, dld, dls, lcfg, lts, r100, r125, bcn, wk, aux;
  logic [STATIC_W-1:0] stat_o;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int q[$];
  ////////////////////////////////////////////////////////////////////////////
  brs_upstream UP (.clk_i(clk_i), .rst_i(rst_i), .pwr_req_i(pwr_req),
    .perst_req_i(perst_req), .supply_o(sup), .refclk_o(rck), .fund_reset_n_o(fund_n));
  brs_reset_seq #(.LINK_TRAIN_MAX_CYC(LTC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .core_supply_sense_i(sup), .refclk_active_i(rck), .fund_reset_n_i(fund_n),
    .global_reset_in_n_i(gl_n), .ref_clock_type_select_i(sel), .static_ctrl_i(stat),
    .eeprom_present_i(eep), .hot_reset_i(hot), .link_up_i(lup), .phy_ready_i(phy),
    .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata), .por_o(por),
    .sticky_rst_o(stk), .eeprom_rst_o(eer), .ordinary_rst_o(ordr), .sec_bus_rst_o(sbr),
    .secondary_bus_reset_bit_o(sbit), .dl_down_o(dld), .static_ctrl_o(stat_o),
    .eeprom_dl_start_o(dls), .link_cfg_o(lcfg), .link_train_start_o(lts),
    .ref_diff100_o(r100), .ref_se125_o(r125), .beacon_o(bcn), .wake_o(wk),
    .aux_power_en_o(aux));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Static inputs settle well ahead of release so the latch sees a clean value.
  task automatic rel_reset(input logic eep_v, input logic use_gl, input logic early);
    int n;
    lfsr_q = lfsr(lfsr_q);
    stat = lfsr_q[7:0];
    q.push_back(int'(lfsr_q[7:0]));
    eep = eep_v;
    repeat (4) @(negedge clk_i);
    if (use_gl)
      gl_n = 1'b1;
    else
      perst_req = 1'b1;
    n = 0;
    while (lcfg !== 1'b1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_bit("link_cfg", 1'b1, lcfg);
    chk_bit("dl_start", eep_v, dls);
    chk_byte("static", 8'(q.pop_front()), stat_o);
    chk_bit("eeprom_rst", 1'b0, eer);
    // An early ready must start training on the very next edge.
    phy = early;
    n = 0;
    while (lts !== 1'b1 && n < LTC + 10)
    begin
      @(negedge clk_i);
      n++;
    end
    phy = 1'b0;
    if (early)
      chk_bit("train_early", 1'b1, n == 1);
    else
      chk_bit("train_bound", 1'b1, n >= LTC - 3 && n <= LTC + 3);
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic pulse_hot(input logic h);
    hot = h;
    lup = ~h;
    @(negedge clk_i);
    hot = 1'b0;
    lup = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    int n;
    lfsr_q = lfsr(lfsr_q);
    sel = lfsr_q[0];
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    pwr_req = 1'b1;
    repeat (100) @(negedge clk_i);
    chk_bit("por_hold", 1'b1, por);
    chk_bit("sticky_por", 1'b1, stk);
    chk_bit("bus_rst_por", 1'b1, sbr);
    n = 100;
    while (por !== 1'b0 && n < 2200)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_bit("por_delay", 1'b1, n >= 2000 && n <= 2020);
    chk_bit("ref_se125", sel, r125);
    chk_bit("ref_diff100", ~sel, r100);
    chk_bit("no_wake", 1'b0, bcn | wk | aux);
    $display("Test power_on done");
    rel_reset(1'b1, 1'b0, 1'b0);
    $display("Test release done");
    cfg_write(BRIDGE_CTRL_OFS, 16'h0040);
    chk_bit("sw_bit", 1'b1, sbit);
    chk_bit("bus_rst_sw", 1'b1, sbr);
    cfg_write(8'h3f, 16'h0000);
    chk_bit("other_addr", 1'b1, sbit);
    lfsr_q = lfsr(lfsr_q);
    cfg_write(BRIDGE_CTRL_OFS, lfsr_q & 16'hffbf);
    chk_bit("sw_clear", 1'b0, sbr);
    cfg_write(BRIDGE_CTRL_OFS, 16'h0040);
    $display("Test config done");
    pulse_hot(1'b1);
    chk_bit("dl_down", 1'b1, dld);
    chk_bit("ord_hot", 1'b1, ordr);
    chk_bit("sw_hot", 1'b0, sbit);
    chk_bit("bus_rst_hot", 1'b1, sbr);
    chk_bit("eer_hot", 1'b0, eer);
    chk_bit("stk_hot", 1'b0, stk);
    pulse_hot(1'b0);
    chk_bit("dl_up", 1'b0, dld);
    chk_bit("bus_free", 1'b0, sbr);
    $display("Test hot_reset done");
    perst_req = 1'b0;
    repeat (6) @(negedge clk_i);
    chk_bit("eer_fund", 1'b1, eer);
    chk_bit("stk_fund", 1'b0, stk);
    chk_bit("bus_rst_fund", 1'b1, sbr);
    rel_reset(1'b0, 1'b0, 1'b1);
    gl_n = 1'b0;
    repeat (6) @(negedge clk_i);
    chk_bit("stk_glob", 1'b1, stk);
    chk_bit("ord_glob", 1'b1, ordr);
    rel_reset(1'b1, 1'b1, 1'b0);
    chk_bit("stk_free", 1'b0, stk);
    $display("Test pin_resets done");
    sel = ~sel;
    repeat (4) @(negedge clk_i);
    chk_bit("ref_se125_flip", sel, r125);
    chk_bit("ref_diff100_flip", ~sel, r100);
    $display("Test ref_select done");
    pwr_req = 1'b0;
    repeat (12) @(negedge clk_i);
    chk_bit("por_loss", 1'b1, por);
    chk_bit("stk_loss", 1'b1, stk);
    $display("Test power_down done");
    finish_test();
  end
endmodule
